/* File: cssu_params.svh */
`ifndef CSSU_PARAMS_SVH
`define CSSU_PARAMS_SVH
// =====================================================
// Register map (byte addresses)
`define CSSU_ADDR_TRIM      12'h000
`define CSSU_ADDR_PRESCALE  12'h004
`define CSSU_ADDR_STATUS    12'h008
`define CSSU_ADDR_TIMERCTL  12'h00C
// =====================================================
// Fuse encodings
`define CSSU_SRC_EXT        4'h0
`define CSSU_SRC_RC         4'h2
`define CSSU_SRC_128K       4'h3
`define CSSU_SUT_BOD        2'h0
`define CSSU_SUT_FAST       2'h1
`define CSSU_SUT_SLOW       2'h2
`define CSSU_SUT_RSVD       2'h3
`define CSSU_DIV1           4'h0
`define CSSU_DIV8           4'h3
// Shipped fuse values
`define CSSU_SHIP_SRC       4'h2
`define CSSU_SHIP_SUT       2'h2
`define CSSU_SHIP_DIV8      1'b1
// =====================================================
// Start-up counts in source clock cycles, except CSSU_CK_RESET, which is counted on watchdog ticks
`define CSSU_CK_LF_SHORT    16'd1024
`define CSSU_CK_LF_LONG     16'd32768
`define CSSU_CK_FAST        16'd6
`define CSSU_CK_RESET       16'd14
// Reset time-out figures in microseconds, clock rate in MHz
`define CSSU_TO_4P1_US      32'd4100
`define CSSU_TO_65_US       32'd65000
`define CSSU_TO_4_US        32'd4000
`define CSSU_TO_64_US       32'd64000
`define CSSU_CLK_MHZ        32'd50
`endif

/* File: cssu_pkg.sv */
package cssu_pkg;
  // =====================================================
  // Start-up sequencer states
  typedef enum logic [1:0] {
    CSSU_IDLE,
    CSSU_SRC_WAIT,
    CSSU_TIMEOUT,
    CSSU_RUN
  } cssu_state_e;
endpackage : cssu_pkg

/* File: cssu_cnt_if.sv */
`timescale 1ns/1ps
// =====================================================
// Start-up counter link between sequencer and counter
interface cssu_cnt_if;
  logic        load;
  logic [31:0] count;
  logic        tick;
  logic        done;
  modport ctrl (output load, output count, output tick, input done);
  modport cnt  (input load, input count, input tick, output done);
endinterface : cssu_cnt_if

/* File: cssu_down_cnt.sv */
`timescale 1ns/1ps
// =====================================================
// Loadable down counter advanced by a tick enable
module cssu_down_cnt
  import cssu_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_in,
  cssu_cnt_if.cnt   cif
);
  logic [31:0] rem_q;

  // Load on request, count down on each tick, hold at zero
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rem_q <= 32'h0000_0000;
    else if (cif.load)
      rem_q <= cif.count;
    else if (cif.tick && (rem_q != 32'h0000_0000))
      rem_q <= rem_q - 32'h0000_0001;
  end

  // Zero count only: the sequencer's reload depends on this, so no load term here
  assign cif.done = (rem_q == 32'h0000_0000);
endmodule : cssu_down_cnt

/* File: cssu_clock_ctrl.sv */
`timescale 1ns/1ps
`include "cssu_params.svh"
module cssu_clock_ctrl
  import cssu_pkg::*;
#(
  parameter logic [7:0]  FACTORY_TRIM = 8'h80,
  parameter logic [3:0]  LFXTAL_CODE  = 4'h6,
  parameter logic [31:0] TICK_DIV     = 32'd1
)
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [3:0]  clock_source_select_fuses_in,
  input  wire logic [1:0]  startup_time_fuses_in,
  input  wire logic        divide_by_eight_fuse_in,
  input  wire logic        wake_in,
  input  wire logic        src_clk_edge_in,
  input  wire logic        wdt_osc_edge_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  source_sel_out,
  output logic      [7:0]  rc_trim_out,
  output logic      [3:0]  prescaler_select_field_out,
  output logic             sys_clk_enable_out,
  output logic             timer_external_clock_select_out,
  output logic             fuse_reserved_out
);
  // =====================================================
  // Time-out cycle counts at the watchdog tick
  localparam logic [31:0] TO_4P1 = `CSSU_TO_4P1_US * `CSSU_CLK_MHZ / TICK_DIV;
  localparam logic [31:0] TO_65  = `CSSU_TO_65_US * `CSSU_CLK_MHZ / TICK_DIV;
  localparam logic [31:0] TO_4   = `CSSU_TO_4_US * `CSSU_CLK_MHZ / TICK_DIV;
  localparam logic [31:0] TO_64  = `CSSU_TO_64_US * `CSSU_CLK_MHZ / TICK_DIV;

  cssu_state_e state_q;
  logic [7:0]  trim_q;
  logic [3:0]  prescale_q;
  logic        timer_ext_q;
  logic        from_reset_q;
  logic [31:0] src_count;
  logic [31:0] to_count;
  logic        known_src;
  logic        apb_wr;
  logic        mapped;

  cssu_cnt_if cif ();

  cssu_down_cnt u_cnt (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .cif      (cif)
  );

  // =====================================================
  // Source decode and start-up counts
  always_comb
  begin
    known_src = 1'b1;
    src_count = {16'h0000, `CSSU_CK_FAST};
    case (clock_source_select_fuses_in)
      `CSSU_SRC_RC:   src_count = {16'h0000, `CSSU_CK_FAST};
      `CSSU_SRC_128K: src_count = {16'h0000, `CSSU_CK_FAST};
      `CSSU_SRC_EXT:  src_count = {16'h0000, `CSSU_CK_FAST};
      default:
      begin
        if (clock_source_select_fuses_in[3:1] == LFXTAL_CODE[3:1])
          src_count = clock_source_select_fuses_in[0] ?
                      {16'h0000, `CSSU_CK_LF_LONG} : {16'h0000, `CSSU_CK_LF_SHORT};
        else
          known_src = 1'b0;
      end
    endcase
  end

  // Reset time-out length chosen by the start-up code
  always_comb
  begin
    case (startup_time_fuses_in)
      `CSSU_SUT_FAST: to_count = (clock_source_select_fuses_in == `CSSU_SRC_128K) ? TO_4 : TO_4P1;
      `CSSU_SUT_SLOW: to_count = (clock_source_select_fuses_in == `CSSU_SRC_128K) ? TO_64 : TO_65;
      default:        to_count = 32'h0000_0000;
    endcase
  end

  // Time-out length per start-up code and source
  to_bod_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (startup_time_fuses_in == `CSSU_SUT_BOD) |-> (to_count == 32'h0000_0000))
    else $error("Time-out not zero for BROWNOUT_DETECTOR code");
  to_fast_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (startup_time_fuses_in == `CSSU_SUT_FAST && clock_source_select_fuses_in != `CSSU_SRC_128K) |->
    (to_count == TO_4P1))
    else $error("Fast time-out length wrong");
  to_slow_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (startup_time_fuses_in == `CSSU_SUT_SLOW && clock_source_select_fuses_in != `CSSU_SRC_128K) |->
    (to_count == TO_65))
    else $error("Slow time-out length wrong");
  fast_128k_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (startup_time_fuses_in == `CSSU_SUT_FAST && clock_source_select_fuses_in == `CSSU_SRC_128K) |->
    (to_count == TO_4))
    else $error("128 kHz fast time-out wrong");

  assign fuse_reserved_out = (startup_time_fuses_in == `CSSU_SUT_RSVD) || !known_src;

  // =====================================================
  // Start-up sequencer driving the shared counter
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_q      <= CSSU_IDLE;
      from_reset_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        CSSU_IDLE:
          if (!fuse_reserved_out)
            state_q <= CSSU_SRC_WAIT;
        CSSU_SRC_WAIT:
          if (cif.done)
            state_q <= from_reset_q ? CSSU_TIMEOUT : CSSU_RUN;
        CSSU_TIMEOUT:
          if (cif.done)
          begin
            state_q      <= CSSU_RUN;
            from_reset_q <= 1'b0;
          end
        CSSU_RUN:
          if (wake_in)
            state_q <= CSSU_SRC_WAIT;
        default:
          state_q <= CSSU_IDLE;
      endcase
    end
  end

  // Counter loads: source count, then 14 CK plus time-out
  always_comb
  begin
    cif.load  = 1'b0;
    cif.count = src_count;
    if ((state_q == CSSU_IDLE) && !fuse_reserved_out)
      cif.load = 1'b1;
    else if ((state_q == CSSU_RUN) && wake_in)
      cif.load = 1'b1;
    else if ((state_q == CSSU_SRC_WAIT) && cif.done && from_reset_q)
    begin
      cif.load  = 1'b1;
      cif.count = to_count + {16'h0000, `CSSU_CK_RESET};
    end
  end

  // Source edges during start-up, watchdog edges during time-out
  assign cif.tick = (state_q == CSSU_TIMEOUT) ? wdt_osc_edge_in : src_clk_edge_in;

  assign sys_clk_enable_out = (state_q == CSSU_RUN);

  // =====================================================
  // APB slave, zero wait states
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr == `CSSU_ADDR_TRIM) || (paddr == `CSSU_ADDR_PRESCALE) ||
                   (paddr == `CSSU_ADDR_STATUS) || (paddr == `CSSU_ADDR_TIMERCTL);
  assign pslverr = psel && penable && !mapped;

  // Trim register: factory value on reset, software later
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      trim_q <= FACTORY_TRIM;
    else if (apb_wr && (paddr == `CSSU_ADDR_TRIM))
      trim_q <= pwdata[7:0];
  end

  // Prescaler select reset follows divide-by-eight fuse
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      prescale_q <= `CSSU_SHIP_DIV8 ? `CSSU_DIV8 : `CSSU_DIV1;
    else if (from_reset_q && (state_q == CSSU_IDLE))
      prescale_q <= divide_by_eight_fuse_in ? `CSSU_DIV8 : `CSSU_DIV1;
    else if (apb_wr && (paddr == `CSSU_ADDR_PRESCALE))
      prescale_q <= pwdata[3:0];
  end

  // Timer external clock select
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      timer_ext_q <= 1'b0;
    else if (apb_wr && (paddr == `CSSU_ADDR_TIMERCTL))
      timer_ext_q <= pwdata[0];
  end

  // Read data registered at the setup phase
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `CSSU_ADDR_TRIM:     prdata <= {24'h000000, trim_q};
        `CSSU_ADDR_PRESCALE: prdata <= {28'h0000000, prescale_q};
        `CSSU_ADDR_STATUS:   prdata <= {26'h0000000, fuse_reserved_out, sys_clk_enable_out,
                                        clock_source_select_fuses_in};
        `CSSU_ADDR_TIMERCTL: prdata <= {31'h00000000, timer_ext_q};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign source_sel_out                  = clock_source_select_fuses_in;
  assign rc_trim_out                     = trim_q;
  assign prescaler_select_field_out      = prescale_q;
  assign timer_external_clock_select_out = timer_ext_q;

  // =====================================================
  // Assertions
  gate_closed_a: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(sys_clk_enable_out) |-> $past(cif.done))
    else $error("Clock released before start-up done");
  trim_write_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (apb_wr && paddr == `CSSU_ADDR_TRIM) |=> (rc_trim_out == $past(pwdata[7:0])))
    else $error("Trim write not applied");
  trim_reset_a: assert property (@(posedge clk_in)
    $past(reset_in) |-> (trim_q == FACTORY_TRIM))
    else $error("Trim not reloaded at reset");
  prescale_div_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (from_reset_q && state_q == CSSU_IDLE && !fuse_reserved_out) |=>
    (prescale_q == ($past(divide_by_eight_fuse_in) ? `CSSU_DIV8 : `CSSU_DIV1)))
    else $error("Prescaler reset value wrong");
  wake_short_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CSSU_RUN && wake_in &&
     clock_source_select_fuses_in inside {`CSSU_SRC_RC, `CSSU_SRC_128K, `CSSU_SRC_EXT}) |->
    (cif.count == {16'h0000, `CSSU_CK_FAST}))
    else $error("Fast source wake count wrong");
  lf_long_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (clock_source_select_fuses_in[3:1] == LFXTAL_CODE[3:1]) |->
    (src_count == (clock_source_select_fuses_in[0] ? {16'h0000, `CSSU_CK_LF_LONG} :
                   {16'h0000, `CSSU_CK_LF_SHORT})))
    else $error("LF crystal start count wrong");
  wdt_tick_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CSSU_TIMEOUT) |-> (cif.tick == wdt_osc_edge_in))
    else $error("Time-out not on watchdog clock");
  slow_128k_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (clock_source_select_fuses_in == `CSSU_SRC_128K && startup_time_fuses_in == `CSSU_SUT_SLOW) |->
    (to_count == TO_64))
    else $error("128 kHz slow time-out wrong");
  reserved_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (fuse_reserved_out && state_q == CSSU_IDLE) |=> (state_q == CSSU_IDLE))
    else $error("Reserved code started clock");
  timer_sel_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (apb_wr && paddr == `CSSU_ADDR_TIMERCTL) |=> (timer_external_clock_select_out == $past(pwdata[0])))
    else $error("Timer clock select not applied");
  trim_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !(apb_wr && paddr == `CSSU_ADDR_TRIM) |=> $stable(trim_q))
    else $error("Trim changed without a write");
  run_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == CSSU_RUN && !wake_in) |=> sys_clk_enable_out)
    else $error("Clock dropped without wake");
  release_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (cif.done && ((state_q == CSSU_TIMEOUT) || (state_q == CSSU_SRC_WAIT && !from_reset_q))) |=>
    sys_clk_enable_out)
    else $error("Clock not released after start-up");
  trim_read_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (psel && !penable && !pwrite && paddr == `CSSU_ADDR_TRIM) |=>
    (prdata == {24'h000000, $past(trim_q)}))
    else $error("Trim read data wrong");

  // Cover points for the main scenarios
  run_reached_c: cover property (@(posedge clk_in) disable iff (reset_in) state_q == CSSU_RUN);
  wake_seen_c:   cover property (@(posedge clk_in) disable iff (reset_in)
    state_q == CSSU_RUN && wake_in);
  trim_wr_c:     cover property (@(posedge clk_in) disable iff (reset_in)
    apb_wr && paddr == `CSSU_ADDR_TRIM);
  timeout_c:     cover property (@(posedge clk_in) disable iff (reset_in)
    state_q == CSSU_TIMEOUT);
  reserved_c:    cover property (@(posedge clk_in) disable iff (reset_in)
    fuse_reserved_out && state_q == CSSU_IDLE);
endmodule : cssu_clock_ctrl

/* File: cssu_src_model.sv */
`timescale 1ns/1ps
// ==================================================
// Far-side oscillators: selected source and watchdog
module cssu_src_model
#(
  parameter int SRC_DIV = 2,
  parameter int WDT_DIV = 4
)
(
  input  wire logic clk_in,
  output logic      src_edge_out,
  output logic      wdt_edge_out
);
  logic [7:0] src_cnt_q = 8'h00;
  logic [7:0] wdt_cnt_q = 8'h00;

  // Source edge pulse at a fixed period, no cycle-to-cycle drift
  always_ff @(posedge clk_in)
  begin
    src_cnt_q    <= (src_cnt_q == 8'(SRC_DIV - 1)) ? 8'h00 : src_cnt_q + 8'h01;
    src_edge_out <= (src_cnt_q == 8'(SRC_DIV - 1));
  end

  // Free-running watchdog oscillator edge pulse
  always_ff @(posedge clk_in)
  begin
    wdt_cnt_q    <= (wdt_cnt_q == 8'(WDT_DIV - 1)) ? 8'h00 : wdt_cnt_q + 8'h01;
    wdt_edge_out <= (wdt_cnt_q == 8'(WDT_DIV - 1));
  end
endmodule : cssu_src_model

/* File: clock_source_startup_select_test.sv */
`timescale 1ns/1ps
`include "cssu_params.svh"
// ==================================================
// Bench for the clock source and start-up block
module clock_source_startup_select_test;
  localparam int         TDIV = 1000;
  localparam logic [7:0] TRIM = 8'h80;
  logic clk_in = 1'b0, reset_in = 1'b1, div8 = 1'b1, wake_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic src_e, wdt_e, en, fres, tsel;
  logic [3:0]  fuses = 4'h2, ssel, psc;
  logic [1:0]  startup_time_fuses = 2'h2;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  trim;
  logic [3:0]  srcs [3] = '{4'h0, 4'h2, 4'h3};
  int failures = 0, num_checks = 0, wcyc = 0;

  // Clock and watchdog
  initial forever #10 clk_in = ~clk_in;
  initial
  begin
    #(90000 * 20);
    failures++;
    wrap_up();
  end

  cssu_src_model #(.SRC_DIV(2), .WDT_DIV(4)) osc (.clk_in(clk_in), .src_edge_out(src_e), .wdt_edge_out(wdt_e));

  cssu_clock_ctrl #(.FACTORY_TRIM(TRIM), .TICK_DIV(TDIV)) uut (
    .clk_in(clk_in), .reset_in(reset_in), .clock_source_select_fuses_in(fuses),
    .startup_time_fuses_in(startup_time_fuses), .divide_by_eight_fuse_in(div8), .wake_in(wake_in),
    .src_clk_edge_in(src_e), .wdt_osc_edge_in(wdt_e), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .source_sel_out(ssel), .rc_trim_out(trim),
    .prescaler_select_field_out(psc), .sys_clk_enable_out(en),
    .timer_external_clock_select_out(tsel), .fuse_reserved_out(fres));

  // ==================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do
      @(posedge clk_in);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write settle before callers look at outputs
    @(negedge clk_in);
  endtask : apb

  // Reset with given fuses, then time the release of the clock
  task automatic start(input logic [3:0] s, input logic [1:0] u, input logic d);
    int cyc, wd, n, t, us;
    us = (u == 2'h0) ? 0 : (u == 2'h1) ? ((s == 4'h3) ? 4000 : 4100) : ((s == 4'h3) ? 64000 : 65000);
    n = (s[3:1] == 3'b011) ? 1024 : 6;
    t = 14 + us * 50 / TDIV;
    @(posedge clk_in);
    fuses <= s;
    startup_time_fuses <= u;
    div8 <= d;
    reset_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    cyc = 0;
    wd = 0;
    while (en !== 1'b1 && cyc < 20000)
    begin
      @(negedge clk_in);
      cyc++;
      if (wdt_e === 1'b1) wd++;
    end
    check(en, 1'b1);
    check(cyc >= n * 2, 1'b1);
    check(wd >= t && wd <= t + n / 2 + 4, 1'b1);
  endtask : start

  task automatic wrap_up();
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // ==================================================
  // Test sequence
  initial
  begin
    for (int s = 0; s < 3; s++)
      for (int u = 0; u < 3; u++)
      begin
        start(srcs[s], 2'(u), 1'(u));
        check(ssel, srcs[s]);
        apb(1'b0, 12'h008, 32'h0);
        check(rd[5:0], {2'b01, srcs[s]});
        apb(1'b0, 12'h004, 32'h0);
        check(rd[3:0], (u % 2 == 1) ? 4'h3 : 4'h0);
        apb(1'b0, 12'h000, 32'h0);
        check(rd[7:0], TRIM);
        apb(1'b1, 12'h000, 32'h0000_005A);
        check(trim, 8'h5A);
      end
    @(posedge clk_in);
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    @(negedge clk_in);
    check(en, 1'b0);
    while (en !== 1'b1 && wcyc < 100)
    begin
      @(negedge clk_in);
      wcyc++;
    end
    check(wcyc >= 2 * `CSSU_CK_FAST && wcyc <= 2 * `CSSU_CK_FAST + 2, 1'b1);
    check(en, 1'b1);
    apb(1'b1, 12'h010, 32'h0000_00FF);
    check(er, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_005A);
    apb(1'b1, 12'h004, 32'h0000_0007);
    check(psc, 4'h7);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    check(tsel, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd[0], 1'b1);
    apb(1'b1, 12'h00C, 32'h0);
    check(tsel, 1'b0);
    start(`CSSU_SHIP_SRC, `CSSU_SHIP_SUT, `CSSU_SHIP_DIV8);
    check(ssel, 4'h2);
    check(psc, 4'h3);
    start(4'h6, 2'h0, 1'b0);
    check(ssel, 4'h6);
    check({`CSSU_SHIP_SRC, `CSSU_SHIP_SUT, `CSSU_SHIP_DIV8}, 7'b0010_10_1);
    @(posedge clk_in);
    startup_time_fuses <= 2'h3;
    reset_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2000) @(negedge clk_in);
    check({fres, en}, 2'b10);
    wrap_up();
  end
endmodule : clock_source_startup_select_test
